// *** dcfg_core.sv ***
// Configuration word store, programmer port and oscillator gain search
`timescale 1ns/1ns
module dcfg_core
  import dcfg_pkg::*;
#(
  parameter logic [31:0] SERIAL0 = 32'h12345678, // Arbitrary value
  parameter logic [31:0] SERIAL1 = 32'h9abcdef0, // Arbitrary value
  parameter logic [31:0] SERIAL2 = 32'h0f1e2d3c, // Arbitrary value
  parameter logic [31:0] SERIAL3 = 32'h4b5a6978, // Arbitrary value
  parameter int SETTLE_25 = SETTLE_25_CYC,
  parameter int SETTLE_6P25 = SETTLE_6P25_CYC,
  parameter int SETTLE_400 = SETTLE_400_CYC,
  parameter int SETTLE_100 = SETTLE_100_CYC
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [15:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  input wire logic [1:0] primary_osc_mode_select,
  input wire logic oscRunning,
  input wire logic ampAboveLow,
  input wire logic ampBelowHigh,
  output logic [3:0] oscGain,
  output logic agcLocked,
  output logic agcFailed,
  output logic debugFull,
  output logic flashProtected
);
  // =========================================================
  // Non-volatile words
  logic [31:0] signatureWord = SIGNATURE_ERASED;
  logic [31:0] protectWord = WORD_ERASED;
  logic [31:0] configWord = WORD_ERASED;
  logic [31:0] configView;
  logic [31:0] liveConfig;
  logic liveProtect;
  logic loaded;
  logic [1:0] mode;
  logic [1:0] modeMeta;
  logic oscSync;
  logic oscMeta;
  logic lowSync;
  logic lowMeta;
  logic highSync;
  logic highMeta;
  logic syncReady;

  // Writes land in the store while the lock bit is set; a cleared lock bit blocks writes at once, the rest takes effect after the next reset
  // Cells stand for flash, so reset must not erase them
  always_ff @(posedge core_clk) begin
    if (regWrite) begin
      if (regAddr == SIGNATURE_OFFSET && protectWord[PROT_LOCK_BIT]) begin
        signatureWord <= regWdata;
      end
      if (regAddr == PROTECT_OFFSET && protectWord[PROT_LOCK_BIT]) begin
        protectWord <= regWdata;
      end
      if (regAddr == CONFIG0_OFFSET && protectWord[PROT_LOCK_BIT]) begin
        configWord <= regWdata;
      end
    end
  end

  // Sampled once after reset release
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      loaded <= 1'b0;
      liveConfig <= WORD_ERASED;
      liveProtect <= 1'b1;
    end else if (!loaded) begin
      loaded <= 1'b1;
      liveConfig <= configView;
      liveProtect <= protectWord[PROT_LOCK_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      modeMeta <= MODE_EXT_CLOCK;
      mode <= MODE_EXT_CLOCK;
      oscMeta <= 1'b0;
      oscSync <= 1'b0;
      lowMeta <= 1'b0;
      lowSync <= 1'b0;
      highMeta <= 1'b0;
      highSync <= 1'b0;
      syncReady <= 1'b0;
    end else begin
      modeMeta <= primary_osc_mode_select;
      mode <= modeMeta;
      oscMeta <= oscRunning;
      oscSync <= oscMeta;
      lowMeta <= ampAboveLow;
      lowSync <= lowMeta;
      highMeta <= ampBelowHigh;
      highSync <= highMeta;
      // Mode reaches the second flop only one edge after loading
      syncReady <= loaded;
    end
  end

  assign debugFull = liveConfig[CFG_DEBUG_BIT];
  assign flashProtected = ~liveProtect;
  assign configView = {signatureWord[SIG_TOP_BIT], configWord[CFG_TOP_BIT-1:0]};

  // =========================================================
  // Register read port
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdata <= 32'h00000000;
    end else if (regRead) begin
      unique case (regAddr)
        SERIAL0_OFFSET: regRdata <= SERIAL0;
        SERIAL1_OFFSET: regRdata <= SERIAL1;
        SERIAL2_OFFSET: regRdata <= SERIAL2;
        SERIAL3_OFFSET: regRdata <= SERIAL3;
        SIGNATURE_OFFSET: regRdata <= liveProtect ? signatureWord : 32'h00000000;
        PROTECT_OFFSET: regRdata <= protectWord;
        CONFIG0_OFFSET: regRdata <= liveProtect ? configView : 32'h00000000;
        STATUS_OFFSET: regRdata <= {26'h0000000, agcFailed, agcLocked, oscGain};
        default: regRdata <= 32'h00000000;
      endcase
    end else begin
      regRdata <= 32'h00000000;
    end
  end

  // =========================================================
  // Automatic gain search
  function automatic int settleCycles(input logic [1:0] sel);
    case (sel)
      SEL_25: settleCycles = SETTLE_25;
      SEL_6P25: settleCycles = SETTLE_6P25;
      SEL_400: settleCycles = SETTLE_400;
      default: settleCycles = SETTLE_100;
    endcase
  endfunction

  dcfg_agc_t agcState;
  logic [31:0] waitCount;
  logic [4:0] stepCount;
  logic lockGood;
  logic [31:0] settleLimit;

  assign lockGood = oscSync & lowSync & highSync;
  assign settleLimit = 32'(settleCycles(liveConfig[CFG_SETTLE_LSB+1:CFG_SETTLE_LSB]));

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      agcState <= DCFG_IDLE;
      waitCount <= 32'h00000000;
      stepCount <= 5'h00;
      oscGain <= GAIN_LOWEST;
      agcLocked <= 1'b0;
      agcFailed <= 1'b0;
    end else begin
      unique case (agcState)
        DCFG_IDLE: begin
          if (syncReady) begin
            if (liveConfig[CFG_AGC_BIT] && mode == MODE_HS_CRYSTAL) begin
              agcState <= DCFG_SETTLE;
              oscGain <= GAIN_LOWEST;
              stepCount <= 5'h01;
              waitCount <= 32'h00000000;
            end else begin
              agcState <= DCFG_MANUAL;
            end
          end
        end
        DCFG_SETTLE: begin
          if (waitCount + 32'h00000001 < settleLimit) begin
            waitCount <= waitCount + 32'h00000001;
          end else if (lockGood) begin
            agcState <= DCFG_LOCKED;
            agcLocked <= 1'b1;
          end else if (stepCount == MAX_STEPS) begin
            agcState <= DCFG_LOCKED;
            agcFailed <= 1'b1;
          end else begin
            oscGain <= oscGain + 4'h1;
            stepCount <= stepCount + 5'h01;
            waitCount <= 32'h00000000;
          end
        end
        DCFG_LOCKED: agcState <= DCFG_LOCKED;
        DCFG_MANUAL: agcState <= DCFG_MANUAL;
      endcase
    end
  end

  // =========================================================
  // Checks
  property p_step_bound;
    @(posedge core_clk) disable iff (!reset_n) stepCount <= MAX_STEPS;
  endproperty
  a_step_bound: assert property (p_step_bound) else $error("step count over limit");

  property p_gain_linear;
    @(posedge core_clk) disable iff (!reset_n)
      (agcState == DCFG_SETTLE && $past(agcState) == DCFG_SETTLE && oscGain != $past(oscGain))
      |-> oscGain == $past(oscGain) + 4'h1;
  endproperty
  a_gain_linear: assert property (p_gain_linear) else $error("gain did not step by one");

  property p_lock_cause;
    @(posedge core_clk) disable iff (!reset_n) $rose(agcLocked) |-> $past(lockGood);
  endproperty
  a_lock_cause: assert property (p_lock_cause) else $error("lock without good amplitude");

  property p_wait_before;
    @(posedge core_clk) disable iff (!reset_n)
      (agcState == DCFG_SETTLE && oscGain != $past(oscGain) && $past(agcState) == DCFG_SETTLE)
      |-> $past(waitCount) + 32'h00000001 >= settleLimit;
  endproperty
  a_wait_before: assert property (p_wait_before) else $error("step taken before settle");

  property p_manual_idle;
    @(posedge core_clk) disable iff (!reset_n) agcState == DCFG_MANUAL |-> !agcLocked && waitCount == 32'h00000000;
  endproperty
  a_manual_idle: assert property (p_manual_idle) else $error("search ran in manual mode");

  property p_hold;
    @(posedge core_clk) disable iff (!reset_n) loaded && $past(loaded) |-> $stable(liveConfig) && $stable(liveProtect);
  endproperty
  a_hold: assert property (p_hold) else $error("sampled words changed");

  property p_top_bit;
    @(posedge core_clk) disable iff (!reset_n)
      $rose(loaded) |-> liveConfig[CFG_TOP_BIT] == $past(signatureWord[SIG_TOP_BIT]);
  endproperty
  a_top_bit: assert property (p_top_bit) else $error("config top bit mismatch");

  property p_protect_read;
    @(posedge core_clk) disable iff (!reset_n)
      regRead && regAddr == CONFIG0_OFFSET && !liveProtect |=> regRdata == 32'h00000000;
  endproperty
  a_protect_read: assert property (p_protect_read) else $error("protected word readable");

  property p_serial;
    @(posedge core_clk) disable iff (!reset_n) regRead && regAddr == SERIAL0_OFFSET |=> regRdata == SERIAL0;
  endproperty
  a_serial: assert property (p_serial) else $error("serial word wrong");

  property p_debug;
    @(posedge core_clk) disable iff (!reset_n) $rose(loaded) |-> debugFull == $past(configWord[CFG_DEBUG_BIT]);
  endproperty
  a_debug: assert property (p_debug) else $error("debug boot level moved");

  property p_auto_off;
    @(posedge core_clk) disable iff (!reset_n)
      agcState == DCFG_IDLE && syncReady && !liveConfig[CFG_AGC_BIT] |=> agcState == DCFG_MANUAL;
  endproperty
  a_auto_off: assert property (p_auto_off) else $error("search started with automatic gain off");

  property p_mode_gate;
    @(posedge core_clk) disable iff (!reset_n)
      agcState == DCFG_IDLE && syncReady && mode != MODE_HS_CRYSTAL |=> agcState == DCFG_MANUAL;
  endproperty
  a_mode_gate: assert property (p_mode_gate) else $error("search started outside crystal mode");

  property p_start;
    @(posedge core_clk) disable iff (!reset_n)
      agcState == DCFG_IDLE && syncReady && liveConfig[CFG_AGC_BIT] && mode == MODE_HS_CRYSTAL
      |=> agcState == DCFG_SETTLE && oscGain == GAIN_LOWEST && stepCount == 5'h01;
  endproperty
  a_start: assert property (p_start) else $error("search did not start at lowest gain");

  property p_fail_cause;
    @(posedge core_clk) disable iff (!reset_n)
      $rose(agcFailed) |-> $past(stepCount) == MAX_STEPS && !$past(lockGood);
  endproperty
  a_fail_cause: assert property (p_fail_cause) else $error("search gave up early");

  property p_locked_hold;
    @(posedge core_clk) disable iff (!reset_n) agcState == DCFG_LOCKED |=> agcState == DCFG_LOCKED && $stable(oscGain);
  endproperty
  a_locked_hold: assert property (p_locked_hold) else $error("gain moved after lock");

  property p_one_outcome;
    @(posedge core_clk) disable iff (!reset_n) !(agcLocked && agcFailed);
  endproperty
  a_one_outcome: assert property (p_one_outcome) else $error("locked and failed together");

  property p_write_block;
    @(posedge core_clk) disable iff (!reset_n)
      regWrite && regAddr == CONFIG0_OFFSET && !protectWord[PROT_LOCK_BIT] |=> $stable(configWord);
  endproperty
  a_write_block: assert property (p_write_block) else $error("protected word altered");

  property p_serial_last;
    @(posedge core_clk) disable iff (!reset_n) regRead && regAddr == SERIAL3_OFFSET |=> regRdata == SERIAL3;
  endproperty
  a_serial_last: assert property (p_serial_last) else $error("last serial word wrong");

  property p_settle_default;
    @(posedge core_clk) disable iff (!reset_n)
      loaded && liveConfig[CFG_SETTLE_LSB+1:CFG_SETTLE_LSB] == SEL_25 |-> settleLimit == 32'(SETTLE_25);
  endproperty
  a_settle_default: assert property (p_settle_default) else $error("default settle time wrong");

  property p_sync_wait;
    @(posedge core_clk) disable iff (!reset_n) !syncReady |-> agcState == DCFG_IDLE;
  endproperty
  a_sync_wait: assert property (p_sync_wait) else $error("search began before inputs settled");
endmodule

// *** dcfg_osc_model.sv ***
// Behavioural crystal oscillator seen by the gain search
`timescale 1ns/1ns
module dcfg_osc_model (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [3:0] oscGain,
  input wire logic [4:0] runGain,
  input wire logic [4:0] ampGain,
  input wire logic ampHot,
  output logic oscRunning,
  output logic ampAboveLow,
  output logic ampBelowHigh
);
  // =========================================================
  // Startup delay after each gain change
  logic [3:0] lastGain;
  logic [2:0] age;
  logic ready;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      lastGain <= 4'h0;
      age <= 3'h0;
    end else if (oscGain != lastGain) begin
      lastGain <= oscGain;
      age <= 3'h0;
    end else if (age != 3'h7) begin
      age <= age + 3'h1;
    end
  end
  // Silent until the crystal has had time to start
  assign ready = (age >= 3'h4) && (oscGain == lastGain);
  // Value 16 means never reached
  assign oscRunning = ready && ({1'b0, oscGain} >= runGain);
  assign ampAboveLow = ready && ({1'b0, oscGain} >= ampGain);
  assign ampBelowHigh = !ampHot;
endmodule

// *** dcfg_pkg.sv ***
// Package with constants and types for the device configuration and oscillator gain search block
package dcfg_pkg;
  // =========================================================
  // Register map
  localparam logic [15:0] SERIAL0_OFFSET = 16'h5020;
  localparam logic [15:0] SERIAL1_OFFSET = 16'h5024;
  localparam logic [15:0] SERIAL2_OFFSET = 16'h5028;
  localparam logic [15:0] SERIAL3_OFFSET = 16'h502c;
  localparam logic [15:0] SIGNATURE_OFFSET = 16'h5040;
  localparam logic [15:0] PROTECT_OFFSET = 16'h5044;
  localparam logic [15:0] CONFIG0_OFFSET = 16'h5048;
  localparam logic [15:0] STATUS_OFFSET = 16'h504c;
  // =========================================================
  // Field positions
  localparam int SIG_TOP_BIT = 31;
  localparam int CFG_TOP_BIT = 31;
  localparam int CFG_DEBUG_BIT = 30;
  localparam int CFG_AGC_BIT = 27;
  localparam int CFG_SETTLE_LSB = 24;
  localparam int PROT_LOCK_BIT = 28;
  // =========================================================
  // Erased-state values and codes
  localparam logic [31:0] SIGNATURE_ERASED = 32'h7fffffff;
  localparam logic [31:0] WORD_ERASED = 32'hffffffff;
  localparam logic [1:0] MODE_EXT_CLOCK = 2'h0;
  localparam logic [1:0] MODE_HS_CRYSTAL = 2'h2;
  localparam logic [4:0] MAX_STEPS = 5'h10;
  localparam logic [3:0] GAIN_LOWEST = 4'h0;
  // =========================================================
  // Settling times
  localparam int CLK_MHZ = 100;
  localparam real SETTLE_25_MS = 25.0;
  localparam real SETTLE_6P25_MS = 6.25;
  localparam real SETTLE_400_MS = 400.0;
  localparam real SETTLE_100_MS = 100.0;
  localparam int SETTLE_25_CYC = int'(SETTLE_25_MS * 1000.0) * CLK_MHZ;
  localparam int SETTLE_6P25_CYC = int'(SETTLE_6P25_MS * 1000.0) * CLK_MHZ;
  localparam int SETTLE_400_CYC = int'(SETTLE_400_MS * 1000.0) * CLK_MHZ;
  localparam int SETTLE_100_CYC = int'(SETTLE_100_MS * 1000.0) * CLK_MHZ;
  localparam logic [1:0] SEL_25 = 2'h3;
  localparam logic [1:0] SEL_6P25 = 2'h2;
  localparam logic [1:0] SEL_400 = 2'h1;
  localparam logic [1:0] SEL_100 = 2'h0;

  typedef enum logic [1:0] {
    DCFG_IDLE = 2'b00,
    DCFG_SETTLE = 2'b01,
    DCFG_LOCKED = 2'b11,
    DCFG_MANUAL = 2'b10
  } dcfg_agc_t;
endpackage

// *** tb_device_config_and_osc_agc.sv ***
// Self-checking testbench for the configuration store and gain search
`timescale 1ns/1ns
module tb_device_config_and_osc_agc;
  import dcfg_pkg::*;
  // =========================================================
  // Signals
  localparam int ST = 20;
  localparam logic [31:0] SN0 = 32'h0badf00d; // Arbitrary value
  localparam logic [31:0] SN1 = 32'h13572468; // Arbitrary value
  localparam logic [31:0] SN2 = 32'hcafe0001; // Arbitrary value
  localparam logic [31:0] SN3 = 32'h2468ace0; // Arbitrary value
  logic core_clk = 0, reset_n = 0, regWrite = 0, regRead = 0, ampHot = 0;
  logic [15:0] regAddr = 16'h0;
  logic [31:0] regWdata = 32'h0, regRdata, rv;
  logic [1:0] modeSel = 2'h2;
  logic [4:0] runGain = 5'h0, ampGain = 5'h0;
  logic [3:0] oscGain;
  logic agcLocked, agcFailed, debugFull, flashProtected, oscRunning, ampAboveLow, ampBelowHigh;
  logic [31:0] sn [4] = '{SN0, SN1, SN2, SN3};
  int error_cnt = 0, samples_checked = 0, seed = 32'h800c, cyc;

  dcfg_core #(.SERIAL0(SN0), .SERIAL1(SN1), .SERIAL2(SN2), .SERIAL3(SN3), .SETTLE_25(ST), .SETTLE_6P25(5),
    .SETTLE_400(80), .SETTLE_100(40)) DUT (.core_clk(core_clk), .reset_n(reset_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .primary_osc_mode_select(modeSel), .oscRunning(oscRunning), .ampAboveLow(ampAboveLow),
    .ampBelowHigh(ampBelowHigh), .oscGain(oscGain), .agcLocked(agcLocked), .agcFailed(agcFailed),
    .debugFull(debugFull), .flashProtected(flashProtected));
  dcfg_osc_model osc (.core_clk(core_clk), .reset_n(reset_n), .oscGain(oscGain), .runGain(runGain),
    .ampGain(ampGain), .ampHot(ampHot), .oscRunning(oscRunning), .ampAboveLow(ampAboveLow),
    .ampBelowHigh(ampBelowHigh));

  initial begin
    forever #5 core_clk = ~core_clk;
  end
  // =========================================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge core_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic rst();
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // One search from reset; the model decides where lock is possible
  task automatic run_case(input logic [1:0] m, input logic [4:0] r, input logic [4:0] a, input logic h);
    logic [4:0] mx;
    logic fail;
    int steps;
    mx = (r > a) ? r : a;
    fail = h || (mx > 5'd15);
    steps = fail ? 16 : int'(mx) + 1;
    @(posedge core_clk);
    modeSel <= m;
    runGain <= r;
    ampGain <= a;
    ampHot <= h;
    rst();
    cyc = 0;
    while (!(agcLocked === 1'b1 || agcFailed === 1'b1) && cyc < 20 * (ST + 6)) begin
      @(posedge core_clk);
      cyc++;
    end
    rd(STATUS_OFFSET, rv);
    if (m != MODE_HS_CRYSTAL) begin
      chk("idleStatus", 32'h0, rv);
    end else if (fail) begin
      chk("failStatus", 32'h20, rv & 32'h30);
    end else begin
      chk("lockStatus", {26'h0, 2'b01, mx[3:0]}, rv);
    end
    if (m == MODE_HS_CRYSTAL) begin
      chk("stepMin", 32'h1, 32'(cyc >= steps * ST));
      chk("stepMax", 32'h1, 32'(cyc <= steps * (ST + 4) + 10));
    end
  endtask
  // =========================================================
  // Main sequence
  initial begin
    rst();
    for (int i = 0; i < 4; i++) begin
      rd(SERIAL0_OFFSET + 16'(4 * i), rv);
      chk("serial", sn[i], rv);
    end
    rd(SIGNATURE_OFFSET, rv);
    chk("signature", 32'h7fffffff, rv);
    rd(CONFIG0_OFFSET, rv);
    chk("configTop", 32'h0, rv & 32'h80000000);
    rd(16'h5030, rv);
    chk("unmapped", 32'h0, rv);
    chk("debugFull", 32'h1, 32'(debugFull));
    chk("protected", 32'h0, 32'(flashProtected));
    wr(SERIAL0_OFFSET, 32'h0);
    rd(SERIAL0_OFFSET, rv);
    chk("serialWrite", SN0, rv);
    wr(SIGNATURE_OFFSET, 32'h7fffffff);
    rd(SIGNATURE_OFFSET, rv);
    chk("signatureStore", 32'h7fffffff, rv);
    // Reduced debug and manual gain, reserved bits kept at one
    wr(CONFIG0_OFFSET, 32'hb7ffffff);
    rd(CONFIG0_OFFSET, rv);
    chk("configStore", 32'h37ffffff, rv);
    rst();
    repeat (8) @(posedge core_clk);
    chk("debugReduced", 32'h0, 32'(debugFull));
    rd(STATUS_OFFSET, rv);
    chk("manualStatus", 32'h0, rv);
    wr(CONFIG0_OFFSET, 32'hffffffff);
    // Reserved bits written as ones, only the protect bit cleared
    wr(PROTECT_OFFSET, 32'hefffffff);
    rd(PROTECT_OFFSET, rv);
    chk("protectStore", 32'hefffffff, rv);
    chk("protectHeld", 32'h0, 32'(flashProtected));
    run_case(2'h2, 5'd0, 5'd0, 1'b0);
    run_case(2'h2, 5'd15, 5'd3, 1'b0);
    run_case(2'h2, 5'd2, 5'd9, 1'b0);
    run_case(2'h2, 5'd16, 5'd0, 1'b0);
    run_case(2'h2, 5'd1, 5'd1, 1'b1);
    run_case(2'h1, 5'd0, 5'd0, 1'b0);
    run_case(2'h3, 5'd0, 5'd0, 1'b0);
    repeat (6) begin
      run_case(2'h2, 5'($unsigned($random(seed)) % 17), 5'($unsigned($random(seed)) % 16),
        1'(($unsigned($random(seed)) % 8) == 0));
    end
    // Protection was sampled at the first search reset
    chk("protectLive", 32'h1, 32'(flashProtected));
    rd(CONFIG0_OFFSET, rv);
    chk("configHidden", 32'h0, rv);
    wr(PROTECT_OFFSET, 32'hffffffff);
    wr(CONFIG0_OFFSET, 32'hf7ffffff);
    rd(PROTECT_OFFSET, rv);
    chk("protectLocked", 32'hefffffff, rv);
    end_of_test();
  end
  initial begin
    // About four times the longest expected run
    #200000;
    error_cnt++;
    end_of_test();
  end
endmodule
